// >>> hdl/scf_pkg.sv
package scf_pkg;

	// ==========================================================
	// widths and fixed values
	localparam int             DIV_WIDTH   = 12;
	localparam int             WORD_WIDTH  = 32;
	localparam int             SYNC_WIDTH  = 16;
	localparam int             FIFO_DEPTH  = 32;
	localparam logic [11:0]    DIV_OFF     = 12'h000;
	localparam logic [11:0]    DIV_STEP    = 12'h001;
	localparam logic [7:0]     DELAY_NONE  = 8'h00;
	localparam logic [7:0]     PERIOD_NONE = 8'h00;
	localparam logic [7:0]     CNT_STEP    = 8'h01;
	localparam logic [8:0]     PCNT_STEP   = 9'h001;
	localparam logic [4:0]     PULSE_STEP  = 5'h01;
	localparam logic [4:0]     PULSE_IDLE  = 5'h00;

	// ==========================================================
	// mode enumerations
	typedef enum logic [1:0] {
		CLK_SRC_DIVIDED,
		CLK_SRC_OTHER,
		CLK_SRC_PIN
	} scf_clk_src_type;

	typedef enum logic [1:0] {
		CLK_OUT_NONE,
		CLK_OUT_CONTINUOUS,
		CLK_OUT_TRANSFER
	} scf_clk_out_type;

	typedef enum logic [3:0] {
		START_CONTINUOUS,
		START_OTHER_SIDE,
		START_FS_LOW,
		START_FS_HIGH,
		START_FS_FALL,
		START_FS_RISE,
		START_FS_CHANGE,
		START_FS_ANY_EDGE,
		START_COMPARE
	} scf_start_type;

	typedef enum logic [2:0] {
		SYNC_INPUT,
		SYNC_NEG_PULSE,
		SYNC_POS_PULSE,
		SYNC_LOW_DATA,
		SYNC_HIGH_DATA,
		SYNC_TOGGLE
	} scf_sync_out_type;

	// ==========================================================
	// configuration and status carriers
	typedef struct packed {
		scf_clk_src_type  clock_source_select;
		logic             clock_invert;
		scf_clk_out_type  clock_output_mode;
		scf_start_type    start_select;
		logic [7:0]       start_delay;
		logic [7:0]       period;
	} scf_clock_mode_type;

	typedef struct packed {
		logic [4:0]       data_length;
		logic [3:0]       words_per_frame;
		logic             msb_first;
		logic [3:0]       sync_length;
		scf_sync_out_type sync_output_select;
		logic             sync_data_enable;
		logic             sync_edge_select;
		logic             data_default;
	} scf_frame_mode_type;

	typedef struct packed {
		logic tx_holding_ready_flag;
		logic tx_all_empty_flag;
		logic rx_holding_ready_flag;
		logic rx_overrun_flag;
		logic tx_sync_seen_flag;
		logic rx_sync_seen_flag;
	} scf_status_type;

endpackage : scf_pkg

// >>> hdl/scf_fifo.sv
`timescale 1ns/1ps
module scf_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	// ==========================================================
	// handshakes; full and empty come from flops
	assign push     = in_valid & in_ready;
	assign pop      = out_valid & out_ready;
	assign out_data = mem[rd_ptr];

	always_comb begin
		next_count = count;
		if (push & ~pop)
			next_count = count + (AW+1)'(1);
		else if (pop & ~push)
			next_count = count - (AW+1)'(1);
	end

	// storage has no reset, only the pointers matter
	always_ff @(posedge core_clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			if (push)
				wr_ptr <= AW'(wr_ptr + AW'(1));
			if (pop)
				rd_ptr <= AW'(rd_ptr + AW'(1));
			count     <= next_count;
			in_ready  <= next_count != (AW+1)'(DEPTH);
			out_valid <= next_count != '0;
		end
	end
endmodule : scf_fifo

// >>> hdl/scf_core.sv
`timescale 1ns/1ps
module scf_core (
	input  wire logic                           core_clk,
	input  wire logic                           reset,
	input  wire scf_pkg::scf_clock_mode_type    tx_clock_mode_cfg,
	input  wire scf_pkg::scf_clock_mode_type    rx_clock_mode_cfg,
	input  wire scf_pkg::scf_frame_mode_type    tx_frame_mode_cfg,
	input  wire scf_pkg::scf_frame_mode_type    rx_frame_mode_cfg,
	input  wire logic [scf_pkg::DIV_WIDTH-1:0]  clock_divisor,
	input  wire logic                           tx_enable,
	input  wire logic                           rx_enable,
	input  wire logic [scf_pkg::WORD_WIDTH-1:0] tx_word,
	input  wire logic                           tx_word_valid,
	output logic                                tx_word_ready,
	input  wire logic [scf_pkg::SYNC_WIDTH-1:0] tx_sync_holding,
	input  wire logic [scf_pkg::SYNC_WIDTH-1:0] rx_compare_pattern,
	input  wire logic                           rx_holding_read,
	input  wire logic                           status_read,
	output logic [scf_pkg::WORD_WIDTH-1:0]      rx_holding,
	output logic [scf_pkg::SYNC_WIDTH-1:0]      rx_sync_holding,
	output scf_pkg::scf_status_type             status_word,
	input  wire logic                           tx_bit_clock_pin_in,
	output logic                                tx_bit_clock_pin_out,
	output logic                                tx_bit_clock_pin_oe_n,
	input  wire logic                           rx_bit_clock_pin_in,
	output logic                                rx_bit_clock_pin_out,
	output logic                                rx_bit_clock_pin_oe_n,
	input  wire logic                           tx_sync_pin_in,
	output logic                                tx_sync_pin_out,
	output logic                                tx_sync_pin_oe_n,
	input  wire logic                           rx_sync_pin_in,
	output logic                                rx_sync_pin_out,
	output logic                                rx_sync_pin_oe_n,
	output logic                                tx_data_pin,
	input  wire logic                           rx_data_pin
);
	import scf_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_DATA} scf_state_type;

	// ==========================================================
	// helpers
	function automatic logic start_hit(input scf_start_type sel, input logic fs,
		input logic fs_prev, input logic other_busy, input logic go, input logic cmp);
		case (sel)
			START_CONTINUOUS:  start_hit = go;
			START_OTHER_SIDE:  start_hit = other_busy;
			START_FS_LOW:      start_hit = ~fs;
			START_FS_HIGH:     start_hit = fs;
			START_FS_FALL:     start_hit = fs_prev & ~fs;
			START_FS_RISE:     start_hit = ~fs_prev & fs;
			START_FS_CHANGE:   start_hit = fs ^ fs_prev;
			START_FS_ANY_EDGE: start_hit = fs ^ fs_prev;
			START_COMPARE:     start_hit = cmp;
			default:           start_hit = 1'b0;
		endcase
	endfunction : start_hit

	// for msb-first, reverse the low len+1 bits so every word leaves bit 0 first
	function automatic logic [WORD_WIDTH-1:0] order_word(input logic [WORD_WIDTH-1:0] w,
		input logic [4:0] len, input logic msb);
		order_word = '0;
		for (int i = 0; i < WORD_WIDTH; i++) begin
			if (i <= int'(len))
				order_word[i] = msb ? w[int'(len) - i] : w[i];
		end
	endfunction : order_word

	function automatic logic [SYNC_WIDTH-1:0] sync_mask(input logic [3:0] len);
		sync_mask = '0;
		for (int i = 0; i < SYNC_WIDTH; i++)
			sync_mask[i] = i <= int'(len);
	endfunction : sync_mask

	// ==========================================================
	// clock divider
	logic [DIV_WIDTH-1:0] div_cnt;
	logic                 div_clk;

	// each level lasts divisor master cycles, so duty stays 50% for odd values
	always_ff @(posedge core_clk) begin
		if (reset || clock_divisor == DIV_OFF) begin
			div_cnt <= DIV_OFF;
			div_clk <= 1'b0;
		end else if (div_cnt >= clock_divisor - DIV_STEP) begin
			div_cnt <= DIV_OFF;
			div_clk <= ~div_clk;
		end else begin
			div_cnt <= div_cnt + DIV_STEP;
		end
	end

	// ==========================================================
	// per-side clock selection; index 0 transmit, 1 receive
	scf_clock_mode_type cm [2];
	scf_frame_mode_type fm [2];
	logic [1:0]         base_clk;
	logic [1:0]         side_clk;
	logic [1:0]         lvl;
	logic [1:0]         lvl_prev;
	logic [1:0]         tick;
	logic [1:0]         busy;
	logic [1:0]         in_data;
	logic [1:0]         start;
	logic [1:0]         fs_lvl;
	logic [1:0]         fs_prev;
	logic [1:0]         fs_pin;
	logic [1:0]         enable;

	assign cm     = '{tx_clock_mode_cfg, rx_clock_mode_cfg};
	assign fm     = '{tx_frame_mode_cfg, rx_frame_mode_cfg};
	assign fs_pin = {rx_sync_pin_in, tx_sync_pin_in};
	assign enable = {rx_enable, tx_enable};

	// "other" takes the other side's own source, which avoids a loop
	always_comb begin
		for (int s = 0; s < 2; s++) begin
			base_clk[s] = (cm[s].clock_source_select == CLK_SRC_PIN) ?
				(s == 0 ? tx_bit_clock_pin_in : rx_bit_clock_pin_in) : div_clk;
		end
		side_clk[0] = (cm[0].clock_source_select == CLK_SRC_OTHER) ?
			base_clk[1] : base_clk[0];
		side_clk[1] = (cm[1].clock_source_select == CLK_SRC_OTHER) ?
			base_clk[0] : base_clk[1];
		for (int s = 0; s < 2; s++)
			lvl[s] = side_clk[s] ^ cm[s].clock_invert;
	end

	// transmit shifts on the falling edge, receive samples on the rising edge
	assign tick[0] = lvl_prev[0] & ~lvl[0];
	assign tick[1] = ~lvl_prev[1] & lvl[1];

	// ==========================================================
	// frame sync generation, clock outputs and sync seen flags
	logic [8:0] period_cnt [2];
	logic [4:0] pulse_cnt  [2];
	logic [1:0] toggle;
	logic [1:0] fs_out;
	logic [1:0] fs_oe_n;
	logic [1:0] clk_out;
	logic [1:0] clk_oe_n;
	logic [1:0] sync_seen;
	logic [1:0] trigger;
	logic [1:0] edge_seen;
	logic       tx_on_line;

	// transmit bits reach the pin one tick after the state moves, so the gated
	// clock follows that window, else the first edge is empty and the last bit unclocked
	always_ff @(posedge core_clk) begin
		if (reset)
			tx_on_line <= 1'b0;
		else if (tick[0])
			tx_on_line <= busy[0];
	end

	always_comb begin
		for (int s = 0; s < 2; s++) begin
			fs_lvl[s]    = (fm[s].sync_output_select == SYNC_INPUT) ? fs_pin[s] : fs_out[s];
			trigger[s]   = tick[s] & ((cm[s].period != PERIOD_NONE) ?
				(period_cnt[s] == {cm[s].period, 1'b1}) : start[s]);
			edge_seen[s] = tick[s] & (fm[s].sync_edge_select ?
				(fs_prev[s] & ~fs_lvl[s]) : (~fs_prev[s] & fs_lvl[s]));
		end
	end

	always_ff @(posedge core_clk) begin
		for (int s = 0; s < 2; s++) begin
			if (reset) begin
				lvl_prev[s]   <= 1'b0;
				fs_prev[s]    <= 1'b0;
				period_cnt[s] <= '0;
				pulse_cnt[s]  <= PULSE_IDLE;
				toggle[s]     <= 1'b0;
				fs_out[s]     <= 1'b0;
				fs_oe_n[s]    <= 1'b1;
				clk_out[s]    <= 1'b0;
				clk_oe_n[s]   <= 1'b1;
				sync_seen[s]  <= 1'b0;
			end else begin
				lvl_prev[s] <= lvl[s];
				clk_out[s]  <= side_clk[s];
				clk_oe_n[s] <= ~((cm[s].clock_output_mode == CLK_OUT_CONTINUOUS) |
					((cm[s].clock_output_mode == CLK_OUT_TRANSFER) &
					(s == 0 ? tx_on_line : busy[s])));
				if (tick[s])
					fs_prev[s] <= fs_lvl[s];
				if (trigger[s]) begin
					period_cnt[s] <= '0;
					pulse_cnt[s]  <= {1'b0, fm[s].sync_length} + PULSE_STEP;
					toggle[s]     <= ~toggle[s];
				end else if (tick[s]) begin
					period_cnt[s] <= period_cnt[s] + PCNT_STEP;
					if (pulse_cnt[s] != PULSE_IDLE)
						pulse_cnt[s] <= pulse_cnt[s] - PULSE_STEP;
				end
				fs_oe_n[s] <= fm[s].sync_output_select == SYNC_INPUT;
				unique case (fm[s].sync_output_select)
					SYNC_NEG_PULSE: fs_out[s] <= pulse_cnt[s] == PULSE_IDLE;
					SYNC_POS_PULSE: fs_out[s] <= pulse_cnt[s] != PULSE_IDLE;
					SYNC_LOW_DATA:  fs_out[s] <= ~in_data[s];
					SYNC_HIGH_DATA: fs_out[s] <= in_data[s];
					SYNC_TOGGLE:    fs_out[s] <= toggle[s];
					default:        fs_out[s] <= 1'b0;
				endcase
				// a detected edge wins over a clear in the same cycle
				sync_seen[s] <= (sync_seen[s] & ~status_read) | edge_seen[s];
			end
		end
	end

	assign tx_bit_clock_pin_out  = clk_out[0];
	assign tx_bit_clock_pin_oe_n = clk_oe_n[0];
	assign rx_bit_clock_pin_out  = clk_out[1];
	assign rx_bit_clock_pin_oe_n = clk_oe_n[1];
	assign tx_sync_pin_out       = fs_out[0];
	assign tx_sync_pin_oe_n      = fs_oe_n[0];
	assign rx_sync_pin_out       = fs_out[1];
	assign rx_sync_pin_oe_n      = fs_oe_n[1];

	// ==========================================================
	// transmit path: fifo, holding register, shift register
	scf_state_type            tx_state;
	logic [WORD_WIDTH-1:0]    fifo_data;
	logic                     fifo_valid;
	logic [WORD_WIDTH-1:0]    tx_hold;
	logic                     tx_hold_full;
	logic [WORD_WIDTH-1:0]    tx_shift;
	logic [7:0]               tx_bit;
	logic [3:0]               tx_word_cnt;
	logic                     tx_load;
	logic [WORD_WIDTH-1:0]    tx_ordered;

	scf_fifo #(.WIDTH(WORD_WIDTH), .DEPTH(FIFO_DEPTH)) tx_fifo (
		.core_clk  (core_clk),
		.reset     (reset),
		.in_data   (tx_word),
		.in_valid  (tx_word_valid),
		.in_ready  (tx_word_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (~tx_hold_full)
	);

	assign busy[0]    = tx_state != ST_IDLE;
	assign in_data[0] = tx_state == ST_DATA;
	assign start[0]   = tx_enable & (tx_state == ST_IDLE) & start_hit(cm[0].start_select,
		fs_lvl[0], fs_prev[0], busy[1], tx_hold_full, 1'b0);
	assign tx_load    = tick[0] & (tx_state == ST_DATA) & (tx_bit == DELAY_NONE)
		& tx_hold_full;
	assign tx_ordered = order_word(tx_hold, tx_frame_mode_cfg.data_length,
		tx_frame_mode_cfg.msb_first);

	// holding register refills from the fifo as soon as it empties
	always_ff @(posedge core_clk) begin
		if (reset) begin
			tx_hold      <= '0;
			tx_hold_full <= 1'b0;
		end else if (tx_load) begin
			tx_hold_full <= 1'b0;
		end else if (~tx_hold_full & fifo_valid) begin
			tx_hold      <= fifo_data;
			tx_hold_full <= 1'b1;
		end
	end

	// a word boundary with nothing held ends the frame instead of underrunning
	always_ff @(posedge core_clk) begin
		if (reset || !tx_enable) begin
			tx_state    <= ST_IDLE;
			tx_bit      <= DELAY_NONE;
			tx_word_cnt <= '0;
			tx_shift    <= '0;
			tx_data_pin <= 1'b0;
		end else if (tick[0]) begin
			unique case (tx_state)
				ST_IDLE: begin
					tx_data_pin <= tx_frame_mode_cfg.data_default;
					tx_bit      <= DELAY_NONE;
					tx_word_cnt <= '0;
					if (start[0])
						tx_state <= (cm[0].start_delay != DELAY_NONE) ? ST_DELAY : ST_DATA;
				end
				ST_DELAY: begin
					// sync data only fits inside the delay, data start cuts it short
					if (tx_frame_mode_cfg.sync_data_enable &&
						tx_bit <= {4'h0, tx_frame_mode_cfg.sync_length})
						tx_data_pin <= tx_sync_holding[tx_bit[3:0]];
					else
						tx_data_pin <= tx_frame_mode_cfg.data_default;
					tx_bit <= tx_bit + CNT_STEP;
					if (tx_bit == cm[0].start_delay - CNT_STEP) begin
						tx_bit   <= DELAY_NONE;
						tx_state <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (tx_bit == DELAY_NONE && !tx_hold_full) begin
						tx_state    <= ST_IDLE;
						tx_data_pin <= tx_frame_mode_cfg.data_default;
					end else begin
						if (tx_load) begin
							tx_data_pin <= tx_ordered[0];
							tx_shift    <= tx_ordered >> 1;
						end else begin
							tx_data_pin <= tx_shift[0];
							tx_shift    <= tx_shift >> 1;
						end
						tx_bit <= tx_bit + CNT_STEP;
						if (tx_bit == {3'h0, tx_frame_mode_cfg.data_length}) begin
							tx_bit      <= DELAY_NONE;
							tx_word_cnt <= tx_word_cnt + 4'h1;
							if (tx_word_cnt == tx_frame_mode_cfg.words_per_frame)
								tx_state <= ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ==========================================================
	// receive path
	scf_state_type         rx_state;
	logic [WORD_WIDTH-1:0] rx_shift;
	logic [WORD_WIDTH-1:0] next_rx_word;
	logic [SYNC_WIDTH-1:0] rx_history;
	logic [7:0]            rx_bit;
	logic [3:0]            rx_word_cnt;
	logic                  rx_done;
	logic                  rx_match;

	assign busy[1]    = rx_state != ST_IDLE;
	assign in_data[1] = rx_state == ST_DATA;
	assign rx_match   = ((rx_history ^ rx_compare_pattern) &
		sync_mask(rx_frame_mode_cfg.sync_length)) == '0;
	assign start[1]   = rx_enable & (rx_state == ST_IDLE) & start_hit(cm[1].start_select,
		fs_lvl[1], fs_prev[1], busy[0], 1'b1, rx_match);
	assign rx_done    = tick[1] & (rx_state == ST_DATA) &
		(rx_bit == {3'h0, rx_frame_mode_cfg.data_length});

	always_comb begin
		next_rx_word = (rx_bit == DELAY_NONE) ? '0 : rx_shift;
		if (rx_frame_mode_cfg.msb_first)
			next_rx_word = {next_rx_word[WORD_WIDTH-2:0], rx_data_pin};
		else
			next_rx_word[rx_bit[4:0]] = rx_data_pin;
	end

	always_ff @(posedge core_clk) begin
		if (reset || !rx_enable) begin
			rx_state        <= ST_IDLE;
			rx_bit          <= DELAY_NONE;
			rx_word_cnt     <= '0;
			rx_shift        <= '0;
			rx_history      <= '0;
		end else if (tick[1]) begin
			rx_history <= {rx_history[SYNC_WIDTH-2:0], rx_data_pin};
			unique case (rx_state)
				ST_IDLE: begin
					rx_bit      <= DELAY_NONE;
					rx_word_cnt <= '0;
					if (start[1])
						rx_state <= (cm[1].start_delay != DELAY_NONE) ? ST_DELAY : ST_DATA;
				end
				ST_DELAY: begin
					rx_bit <= rx_bit + CNT_STEP;
					if (rx_bit == cm[1].start_delay - CNT_STEP) begin
						rx_bit   <= DELAY_NONE;
						rx_state <= ST_DATA;
					end
				end
				ST_DATA: begin
					rx_shift <= next_rx_word;
					rx_bit   <= rx_bit + CNT_STEP;
					if (rx_done) begin
						rx_bit      <= DELAY_NONE;
						rx_word_cnt <= rx_word_cnt + 4'h1;
						if (rx_word_cnt == rx_frame_mode_cfg.words_per_frame)
							rx_state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// sync data is caught during the start delay window
	always_ff @(posedge core_clk) begin
		if (reset)
			rx_sync_holding <= '0;
		else if (tick[1] && rx_state == ST_DELAY &&
			rx_bit <= {4'h0, rx_frame_mode_cfg.sync_length})
			rx_sync_holding[rx_bit[3:0]] <= rx_data_pin;
	end

	// ==========================================================
	// holding register and status flags; a new event beats a same-cycle clear
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rx_holding  <= '0;
			status_word <= '{tx_holding_ready_flag: 1'b1, tx_all_empty_flag: 1'b1,
				default: 1'b0};
		end else begin
			if (rx_done)
				rx_holding <= next_rx_word;
			status_word.rx_holding_ready_flag <=
				(status_word.rx_holding_ready_flag & ~rx_holding_read) | rx_done;
			status_word.rx_overrun_flag <= (status_word.rx_overrun_flag & ~status_read) |
				(rx_done & status_word.rx_holding_ready_flag & ~rx_holding_read);
			status_word.tx_holding_ready_flag <= ~tx_hold_full;
			status_word.tx_all_empty_flag <= ~tx_hold_full & ~in_data[0];
			status_word.tx_sync_seen_flag <= sync_seen[0];
			status_word.rx_sync_seen_flag <= sync_seen[1];
		end
	end
endmodule : scf_core

// >>> dv/scf_codec_model.sv
`timescale 1ns/1ps
// ==========
// far-side codec: pull-downs on clock and transmit sync pins, transmit data looped back
module scf_codec_model (
	input  wire logic        core_clk,
	input  wire logic        tx_bit_clock_pin_out,
	input  wire logic        tx_bit_clock_pin_oe_n,
	input  wire logic        rx_bit_clock_pin_out,
	input  wire logic        rx_bit_clock_pin_oe_n,
	input  wire logic        tx_sync_pin_out,
	input  wire logic        tx_sync_pin_oe_n,
	input  wire logic        rx_sync_pin_out,
	input  wire logic        rx_sync_pin_oe_n,
	input  wire logic        tx_data_pin,
	output logic             tx_bit_clock_pin_in,
	output logic             rx_bit_clock_pin_in,
	output logic             tx_sync_pin_in,
	output logic             rx_sync_pin_in,
	output logic             rx_data_pin,
	output logic [31:0]      got_word,
	output logic             got_valid
);
	logic [31:0] sh;
	logic [4:0]  cnt = 5'h00;
	logic        last_ck = 1'h0;
	// codec never drives a clock pin, so it stands still and stays in limits
	assign tx_bit_clock_pin_in = !tx_bit_clock_pin_oe_n & tx_bit_clock_pin_out;
	assign rx_bit_clock_pin_in = !rx_bit_clock_pin_oe_n & rx_bit_clock_pin_out;
	assign tx_sync_pin_in = !tx_sync_pin_oe_n & tx_sync_pin_out;
	// transmit sync is echoed onto the receive sync pin
	assign rx_sync_pin_in = rx_sync_pin_oe_n ? tx_sync_pin_in : rx_sync_pin_out;
	assign rx_data_pin = tx_data_pin;
	// msb-first capture on rising pin clock, data moved half a bit before
	always @(posedge core_clk) begin
		got_valid <= 1'h0;
		last_ck <= tx_bit_clock_pin_in;
		if (tx_bit_clock_pin_in && !last_ck) begin
			sh = {sh[30:0], tx_data_pin};
			cnt <= cnt + 5'h01;
			if (cnt == 5'h1F) begin
				got_word <= sh;
				got_valid <= 1'h1;
			end
		end
	end
endmodule : scf_codec_model

// >>> dv/scf_core_chk.sv
`timescale 1ns/1ps
module scf_core_chk (
	input wire logic                        core_clk,
	input wire logic                        reset,
	input wire scf_pkg::scf_clock_mode_type rx_clock_mode_cfg,
	input wire scf_pkg::scf_frame_mode_type tx_frame_mode_cfg,
	input wire scf_pkg::scf_frame_mode_type rx_frame_mode_cfg,
	input wire logic [11:0]                 clock_divisor,
	input wire logic                        rx_holding_read,
	input wire logic [31:0]                 rx_holding,
	input wire scf_pkg::scf_status_type     status_word,
	input wire logic                        rx_bit_clock_pin_out,
	input wire logic                        rx_bit_clock_pin_oe_n,
	input wire logic                        tx_sync_pin_out,
	input wire logic                        tx_sync_pin_oe_n,
	input wire logic                        rx_sync_pin_in,
	input wire logic                        rx_sync_pin_oe_n
);
	import scf_pkg::*;
	// ==========
	// helpers: settle count, clock level length, sync pulse length
	logic [1:0]  up;
	logic [1:0]  edges;
	logic        last_ck;
	logic [13:0] run;
	logic [17:0] hi;
	wire  [17:0] pw = ({14'h0, tx_frame_mode_cfg.sync_length} + 18'h1) * {5'h0, clock_divisor, 1'h0};
	wire         ck_chg = rx_bit_clock_pin_out != last_ck;
	always_ff @(posedge core_clk) begin
		up <= reset ? 2'h0 : (up == 2'h3 ? up : up + 2'h1);
		edges <= reset ? 2'h0 : (ck_chg && edges != 2'h2 ? edges + 2'h1 : edges);
	end
	// the first level after reset may be partial, so edges gates the check
	always_ff @(posedge core_clk) begin
		last_ck <= rx_bit_clock_pin_out;
		run <= ck_chg ? 14'h1 : run + 14'h1;
		hi <= (reset || !tx_sync_pin_out) ? 18'h0 : hi + 18'h1;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	reset_state_a: assert property (disable iff (1'h0) reset |=> status_word == 6'h30
		&& tx_sync_pin_oe_n && rx_bit_clock_pin_oe_n) else $error("bad state after reset");
	empty_ready_a: assert property (status_word.tx_all_empty_flag
		|-> status_word.tx_holding_ready_flag) else $error("empty while holding full");
	cont_clock_a: assert property (up == 2'h3
		&& rx_clock_mode_cfg.clock_output_mode == CLK_OUT_CONTINUOUS
		|-> !rx_bit_clock_pin_oe_n) else $error("continuous clock pin not driven");
	divider_level_a: assert property (edges == 2'h2 && ck_chg
		&& rx_clock_mode_cfg.clock_output_mode == CLK_OUT_CONTINUOUS
		|-> run == {2'h0, clock_divisor}) else $error("divided clock level length wrong");
	sync_drive_a: assert property (up == 2'h3
		|-> (tx_frame_mode_cfg.sync_output_select == SYNC_INPUT) == tx_sync_pin_oe_n
		&& (rx_frame_mode_cfg.sync_output_select == SYNC_INPUT) == rx_sync_pin_oe_n)
		else $error("sync pin drive wrong");
	pulse_width_a: assert property ($fell(tx_sync_pin_out)
		&& tx_frame_mode_cfg.sync_output_select == SYNC_POS_PULSE |-> hi == pw)
		else $error("sync pulse width wrong");
	sync_seen_a: assert property ($rose(rx_sync_pin_in) && rx_sync_pin_oe_n
		&& clock_divisor == 12'h002 && !rx_frame_mode_cfg.sync_edge_select
		|-> ##[1:5] status_word.rx_sync_seen_flag)
		else $error("sync edge not flagged");
	overrun_hold_a: assert property ($rose(status_word.rx_overrun_flag)
		|-> status_word.rx_holding_ready_flag && $past(status_word.rx_holding_ready_flag))
		else $error("overrun without unread word");
	ready_clear_a: assert property ($past(rx_holding_read) && $stable(rx_holding)
		|-> !status_word.rx_holding_ready_flag) else $error("ready not cleared by read");
endmodule : scf_core_chk
bind scf_core scf_core_chk chk_u (.*);

// >>> dv/sync_serial_clock_frame_core_tb.sv
`timescale 1ns/1ps
module sync_serial_clock_frame_core_tb;
	import scf_pkg::*;
	// ==========
	// nets joined to the design and codec by name
	logic               core_clk, reset, tx_enable, rx_enable, tx_word_valid, tx_word_ready;
	scf_clock_mode_type tx_clock_mode_cfg, rx_clock_mode_cfg;
	scf_frame_mode_type tx_frame_mode_cfg, rx_frame_mode_cfg;
	logic [11:0]        clock_divisor;
	logic [31:0]        tx_word, rx_holding, got_word, sent_q[$], seen_q[$];
	logic [15:0]        tx_sync_holding, rx_compare_pattern, rx_sync_holding;
	scf_status_type     status_word;
	logic               rx_holding_read, status_read, got_valid, tx_data_pin, rx_data_pin;
	logic               tx_bit_clock_pin_in, tx_bit_clock_pin_out, tx_bit_clock_pin_oe_n;
	logic               rx_bit_clock_pin_in, rx_bit_clock_pin_out, rx_bit_clock_pin_oe_n;
	logic               tx_sync_pin_in, tx_sync_pin_out, tx_sync_pin_oe_n;
	logic               rx_sync_pin_in, rx_sync_pin_out, rx_sync_pin_oe_n;
	int                 n_errors = 0, tests_run = 0, seed;
	scf_core dut_u (.*);
	scf_codec_model codec_u (.*);
	initial core_clk = 1'h0;
	always #50 core_clk = ~core_clk;
	always @(posedge core_clk) if (got_valid === 1'h1) seen_q.push_back(got_word);
	function automatic logic [5:0] idle_flags();
		return 6'h30;
	endfunction : idle_flags
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic results();
		$display("mismatches %0d of %0d checks", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : results
	// watchdog: a drain of the full fifo needs well under this many cycles
	initial begin
		#(100 * 40000);
		n_errors++;
		results();
	end
	// ==========
	// fill the fifo with the transmitter held off, then drain and audit flags
	initial begin
		{reset, rx_enable, tx_enable, tx_word_valid, rx_holding_read, status_read} = 6'h30;
		tx_word = 32'hFFFFFFFF;
		clock_divisor = 12'h002;
		seed = $urandom(19637);
		tx_sync_holding = $urandom;
		rx_compare_pattern = $urandom;
		tx_clock_mode_cfg = '{CLK_SRC_DIVIDED, 1'h0, CLK_OUT_TRANSFER, START_CONTINUOUS,
			DELAY_NONE, PERIOD_NONE};
		rx_clock_mode_cfg = '{CLK_SRC_OTHER, 1'h1, CLK_OUT_CONTINUOUS, START_OTHER_SIDE,
			DELAY_NONE, PERIOD_NONE};
		tx_frame_mode_cfg = '{5'h1F, 4'h0, 1'h1, 4'($urandom_range(3)), SYNC_POS_PULSE,
			1'h0, 1'h0, 1'h0};
		rx_frame_mode_cfg = '{5'h1F, 4'h0, 1'h1, 4'h0, SYNC_INPUT, 1'h0, 1'h0, 1'h0};
		repeat (10) @(posedge core_clk);
		reset <= 1'h0;
		repeat (2) @(posedge core_clk);
		tx_word_valid <= 1'h1;
		#1 chk("reset status", idle_flags(), status_word);
		for (int i = 1; i < 40; i++) begin
			@(negedge core_clk);
			if (tx_word_ready !== 1'h1) break;
			@(posedge core_clk);
			sent_q.push_back(tx_word);
			tx_word <= (i == 1) ? 32'h00000001 : $urandom;
		end
		@(posedge core_clk);
		tx_word_valid <= 1'h0;
		chk("words taken", FIFO_DEPTH + 1, sent_q.size());
		tx_enable <= 1'h1;
		for (int i = 0; i < 30000 && seen_q.size() < sent_q.size(); i++) @(posedge core_clk);
		repeat (40) @(posedge core_clk);
		chk("word count", sent_q.size(), seen_q.size());
		foreach (sent_q[i]) chk("word", sent_q[i], seen_q[i]);
		#1 chk("tx flags", 2'h3, status_word[5:4]);
		chk("rx flags", 3'h7, {status_word[3:2], status_word[0]});
		chk("rx holding", sent_q[sent_q.size() - 1], rx_holding);
		@(posedge core_clk) status_read <= 1'h1;
		@(posedge core_clk) status_read <= 1'h0;
		rx_holding_read <= 1'h1;
		@(posedge core_clk) rx_holding_read <= 1'h0;
		#1 chk("cleared flags", 3'h0, {status_word[3:2], status_word[0]});
		results();
	end
endmodule : sync_serial_clock_frame_core_tb
